// [design/twrs_pkg.sv]
/*
  Constants, types and state codes of the two-wire register slave.
  Assumes a link clock fast enough to oversample the serial clock.
*/
// Behaviour
// - serial clock up to 400kHz works
// - one bit per clock, nine per byte
// - data change while clock high is control
// - both lines released high when idle
// - falling data, clock high, means start
// - rising data, clock high, means stop
// - receiver acknowledges by holding data low
// - not-acknowledge leaves data line high
// - seven-bit address, base 1100000, direction bit
// - strap picks C0/C1 or C2/C3
// - acknowledge own address, then serve direction
// - write: register address byte acknowledged first
// - msb first, stored data bytes acknowledged
// - further write bytes go to next register
// - write stays open until stop
// - read begins with write of register address
// - repeated start, read address acknowledged
// - read data shifted out msb first
// - master ack continues, nack ends data
// - read ends at master nack or at stop

`default_nettype none

package twrs_pkg;

  typedef logic [7:0] twrs_byte_t;

  // upper six bits of the bus address, strap fills the lowest
  localparam logic [5:0] ADDR_BASE = 6'h30;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam twrs_byte_t PTR_STEP = 8'h01;
  localparam twrs_byte_t BYTE_ZERO = 8'h00;

  // fastest serial clock and the least link clock to follow it
  localparam int SCL_MAX_KHZ = 400;
  localparam int SAMPLES_PER_HALF = 8;
  localparam int LINK_MIN_KHZ = SCL_MAX_KHZ * 2 * SAMPLES_PER_HALF;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_ADDR_ACK = 9'h004,
    ST_REG = 9'h008,
    ST_REG_ACK = 9'h010,
    ST_WDATA = 9'h020,
    ST_WDATA_ACK = 9'h040,
    ST_RDATA = 9'h080,
    ST_RACK = 9'h100
  } twrs_state_t;

endpackage

`default_nettype wire

// [design/twrs_slave.sv]
/*
  Two-wire register slave: serial side on link_clk, register port on clock.
  Assumes open-drain wiring outside and a register file that answers a read
  strobe on the following clock.
*/

`default_nettype none

module twrs_slave (
  input wire logic clock,
  input wire logic resetn,
  input wire logic link_clk,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic addr_sel,
  output logic reg_wr,
  output logic reg_rd,
  output twrs_pkg::twrs_byte_t reg_addr,
  output twrs_pkg::twrs_byte_t reg_wdata,
  input wire twrs_pkg::twrs_byte_t reg_rdata
);
  import twrs_pkg::*;

  logic link_rstn_s1_q, link_rstn_q;
  logic [2:0] pin_s1_q, pin_s2_q;
  logic scl_s, sda_s, addr_s, scl_p_q, sda_p_q;
  logic scl_rise, scl_fall, start_det, stop_det, rx_state, byte_in, addr_match, busy;
  twrs_state_t state_q;
  logic [3:0] cnt_q;
  twrs_byte_t rx_q, tx_q, ptr_q, rd_buf_q;
  logic rw_q, mack_q, sda_oe_q;
  logic req_tgl_q, req_wr_q;
  twrs_byte_t req_addr_q, req_data_q;
  logic ack_s1_q, ack_s2_q, ack_s3_q;
  logic req_s1_q, req_s2_q, req_s3_q, ack_tgl_q;
  logic reg_wr_q, reg_rd_q;
  logic rd_dly_q;
  twrs_byte_t reg_addr_q, reg_wdata_q, sys_rd_q;

  // link-side reset: async assert, release aligned to link_clk
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      link_rstn_s1_q <= 1'b0;
      link_rstn_q <= 1'b0;
    end else begin
      link_rstn_s1_q <= 1'b1;
      link_rstn_q <= link_rstn_s1_q;
    end
  end

  // pins are asynchronous to link_clk, two flops before use
  always_ff @(posedge link_clk or negedge link_rstn_q) begin
    if (!link_rstn_q) begin
      pin_s1_q <= 3'h3;
      pin_s2_q <= 3'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      pin_s1_q <= {addr_sel, sda_i, scl};
      pin_s2_q <= pin_s1_q;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign scl_s = pin_s2_q[0];
  assign sda_s = pin_s2_q[1];
  assign addr_s = pin_s2_q[2];

  // edges and bus conditions; data moving under a high clock is control
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign rx_state = (state_q == ST_ADDR) | (state_q == ST_REG) | (state_q == ST_WDATA);
  assign byte_in = scl_fall & (cnt_q == BYTE_BITS);
  assign addr_match = (rx_q[7:1] == {ADDR_BASE, addr_s});
  assign busy = req_tgl_q ^ ack_s2_q;

  // transaction sequencing; start wins from any state
  always_ff @(posedge link_clk or negedge link_rstn_q) begin
    if (!link_rstn_q) begin
      state_q <= ST_IDLE;
    end else if (start_det) begin
      state_q <= ST_ADDR;
    end else if (stop_det) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: state_q <= ST_IDLE;
        ST_ADDR: begin
          if (byte_in) begin
            state_q <= addr_match ? ST_ADDR_ACK : ST_IDLE;
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            state_q <= rw_q ? ST_RDATA : ST_REG;
          end
        end
        ST_REG: begin
          if (byte_in) begin
            state_q <= ST_REG_ACK;
          end
        end
        ST_REG_ACK: begin
          if (scl_fall) begin
            state_q <= ST_WDATA;
          end
        end
        ST_WDATA: begin
          if (byte_in) begin
            state_q <= ST_WDATA_ACK;
          end
        end
        ST_WDATA_ACK: begin
          if (scl_fall) begin
            state_q <= ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (scl_fall && cnt_q == LAST_TX_BIT) begin
            state_q <= ST_RACK;
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            state_q <= mack_q ? ST_RDATA : ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // bit counter: received bits on rise, sent bits on fall
  always_ff @(posedge link_clk or negedge link_rstn_q) begin
    if (!link_rstn_q) begin
      cnt_q <= CNT_ZERO;
    end else if (start_det) begin
      cnt_q <= CNT_ZERO;
    end else if (scl_rise && rx_state) begin
      cnt_q <= cnt_q + CNT_ONE;
    end else if (scl_fall && state_q == ST_RDATA) begin
      cnt_q <= cnt_q + CNT_ONE;
    end else if (scl_fall && (state_q == ST_ADDR_ACK || state_q == ST_REG_ACK ||
                              state_q == ST_WDATA_ACK || state_q == ST_RACK)) begin
      cnt_q <= CNT_ZERO;
    end
  end

  // receive shifter, msb arrives first
  always_ff @(posedge link_clk or negedge link_rstn_q) begin
    if (!link_rstn_q) begin
      rx_q <= BYTE_ZERO;
    end else if (scl_rise && rx_state) begin
      rx_q <= {rx_q[6:0], sda_s};
    end
  end

  // direction bit and the master's answer on the ninth clock
  always_ff @(posedge link_clk or negedge link_rstn_q) begin
    if (!link_rstn_q) begin
      rw_q <= 1'b0;
      mack_q <= 1'b0;
    end else begin
      if (state_q == ST_ADDR && byte_in) begin
        rw_q <= rx_q[0];
      end
      if (state_q == ST_RACK && scl_rise) begin
        mack_q <= ~sda_s;
      end
    end
  end

  // transmit shifter, loaded from the prefetched byte
  always_ff @(posedge link_clk or negedge link_rstn_q) begin
    if (!link_rstn_q) begin
      tx_q <= BYTE_ZERO;
    end else if (scl_fall && ((state_q == ST_ADDR_ACK && rw_q) || (state_q == ST_RACK && mack_q))) begin
      tx_q <= rd_buf_q;
    end else if (scl_fall && state_q == ST_RDATA) begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // open-drain data drive; changes just after a clock fall, released at start or stop
  always_ff @(posedge link_clk or negedge link_rstn_q) begin
    if (!link_rstn_q) begin
      sda_oe_q <= 1'b0;
    end else if (start_det || stop_det) begin
      sda_oe_q <= 1'b0;
    end else if (scl_fall) begin
      case (state_q)
        ST_ADDR: sda_oe_q <= (cnt_q == BYTE_BITS) & addr_match;
        ST_ADDR_ACK: sda_oe_q <= rw_q & ~rd_buf_q[7];
        ST_REG: sda_oe_q <= (cnt_q == BYTE_BITS);
        ST_WDATA: sda_oe_q <= (cnt_q == BYTE_BITS) & ~busy;
        ST_RDATA: sda_oe_q <= (cnt_q != LAST_TX_BIT) & ~tx_q[6];
        ST_RACK: sda_oe_q <= mack_q & ~rd_buf_q[7];
        default: sda_oe_q <= 1'b0;
      endcase
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = sda_oe_q;

  // register pointer and requests toward the register side
  always_ff @(posedge link_clk or negedge link_rstn_q) begin
    if (!link_rstn_q) begin
      ptr_q <= BYTE_ZERO;
      req_tgl_q <= 1'b0;
      req_wr_q <= 1'b0;
      req_addr_q <= BYTE_ZERO;
      req_data_q <= BYTE_ZERO;
    end else if (state_q == ST_REG && byte_in) begin
      ptr_q <= rx_q;
    end else if (state_q == ST_ADDR && byte_in && addr_match && rx_q[0]) begin
      req_tgl_q <= ~req_tgl_q;
      req_wr_q <= 1'b0;
      req_addr_q <= ptr_q;
    end else if (state_q == ST_WDATA && byte_in && !busy) begin
      ptr_q <= ptr_q + PTR_STEP;
      req_tgl_q <= ~req_tgl_q;
      req_wr_q <= 1'b1;
      req_addr_q <= ptr_q;
      req_data_q <= rx_q;
    end else if (state_q == ST_RACK && scl_rise) begin
      ptr_q <= ptr_q + PTR_STEP;
      if (!sda_s) begin
        req_tgl_q <= ~req_tgl_q;
        req_wr_q <= 1'b0;
        req_addr_q <= ptr_q + PTR_STEP;
      end
    end
  end

  // completion toggle back from the register side
  always_ff @(posedge link_clk or negedge link_rstn_q) begin
    if (!link_rstn_q) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_s3_q <= 1'b0;
    end else begin
      ack_s1_q <= ack_tgl_q;
      ack_s2_q <= ack_s1_q;
      ack_s3_q <= ack_s2_q;
    end
  end

  // read data is held on the far side until the next request
  always_ff @(posedge link_clk or negedge link_rstn_q) begin
    if (!link_rstn_q) begin
      rd_buf_q <= BYTE_ZERO;
    end else if ((ack_s2_q ^ ack_s3_q) && !req_wr_q) begin
      rd_buf_q <= sys_rd_q;
    end
  end

  // register side: catch the request toggle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
    end else begin
      req_s1_q <= req_tgl_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
    end
  end

  // one-cycle strobes; request fields are stable while the toggle travels
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
      reg_addr_q <= BYTE_ZERO;
      reg_wdata_q <= BYTE_ZERO;
    end else begin
      reg_wr_q <= (req_s2_q ^ req_s3_q) & req_wr_q;
      reg_rd_q <= (req_s2_q ^ req_s3_q) & ~req_wr_q;
      if (req_s2_q ^ req_s3_q) begin
        reg_addr_q <= req_addr_q;
        reg_wdata_q <= req_data_q;
      end
    end
  end

  // read data taken one clock after the strobe, once a registered file has answered
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sys_rd_q <= BYTE_ZERO;
      ack_tgl_q <= 1'b0;
      rd_dly_q <= 1'b0;
    end else begin
      rd_dly_q <= reg_rd_q;
      if (rd_dly_q) begin
        sys_rd_q <= reg_rdata;
      end
      if (reg_wr_q || rd_dly_q) begin
        ack_tgl_q <= ~ack_tgl_q;
      end
    end
  end

  assign reg_wr = reg_wr_q;
  assign reg_rd = reg_rd_q;
  assign reg_addr = reg_addr_q;
  assign reg_wdata = reg_wdata_q;

  // single- and multi-step pieces for the checks below
  sequence s_addr_done;
    state_q == ST_ADDR && byte_in;
  endsequence

  sequence s_acking;
    state_q == ST_ADDR_ACK && sda_oe_q;
  endsequence

  sequence s_released;
    !sda_oe_q [*4];
  endsequence

  chk_start_to_addr: assert property (@(posedge link_clk) disable iff (!link_rstn_q)
    start_det |=> state_q == ST_ADDR && cnt_q == CNT_ZERO)
    else $error("start not taken");

  chk_stop_to_idle: assert property (@(posedge link_clk) disable iff (!link_rstn_q)
    stop_det && !start_det |=> state_q == ST_IDLE && !sda_oe_q)
    else $error("stop did not end transfer");

  chk_addr_ack: assert property (@(posedge link_clk) disable iff (!link_rstn_q)
    s_addr_done and addr_match |=> s_acking)
    else $error("own address not acknowledged");

  chk_other_addr: assert property (@(posedge link_clk) disable iff (!link_rstn_q)
    s_addr_done and !addr_match and !start_det and !stop_det |=> state_q == ST_IDLE ##0 s_released)
    else $error("foreign address drew a response");

  chk_drive_edge: assert property (@(posedge link_clk) disable iff (!link_rstn_q)
    $changed(sda_oe_q) |-> !$past(scl_s) || $past(start_det || stop_det))
    else $error("data drive moved while clock high");

  chk_ptr_load: assert property (@(posedge link_clk) disable iff (!link_rstn_q)
    state_q == ST_REG && byte_in && !start_det && !stop_det |=> ptr_q == $past(rx_q) && sda_oe_q)
    else $error("register address not loaded");

  chk_nack_end: assert property (@(posedge link_clk) disable iff (!link_rstn_q)
    state_q == ST_RACK && scl_fall && !mack_q && !start_det && !stop_det |=> state_q == ST_IDLE)
    else $error("not-acknowledge did not end data");

  chk_tx_shift: assert property (@(posedge link_clk) disable iff (!link_rstn_q)
    state_q == ST_RDATA && scl_fall && cnt_q != LAST_TX_BIT && !start_det && !stop_det
    |=> tx_q == {$past(tx_q[6:0]), 1'b0} && sda_oe_q == ~tx_q[7])
    else $error("read bit not msb first");

  chk_wr_strobe: assert property (@(posedge clock) disable iff (!resetn)
    (req_s2_q ^ req_s3_q) && req_wr_q |=> reg_wr && reg_addr == req_addr_q ##1 !reg_wr)
    else $error("write strobe missing");

  chk_rd_return: assert property (@(posedge clock) disable iff (!resetn)
    reg_rd |=> ##1 sys_rd_q == $past(reg_rdata) && $changed(ack_tgl_q))
    else $error("read data not returned");

  chk_rd_single: assert property (@(posedge clock) disable iff (!resetn)
    reg_rd |=> !reg_rd && !reg_wr)
    else $error("read strobe longer than one cycle");

endmodule

`default_nettype wire

// [verification/twrs_master.sv]
/*
  Bus master model for the two-wire register slave: drives scl and
  pulls or releases sda, one task per bus step.
  Assumes the bench resolves the open-drain sda wire with a pull-up
  and feeds a 50 MHz clock.
*/
`default_nettype none

module twrs_master
  import twrs_pkg::*;
(
  input wire logic clock,
  input wire logic sda_line,
  output logic scl,
  output logic sda_rel
);
  timeunit 1ns;
  timeprecision 1ps;

  // half period in clocks; 64 x 20 ns high, 80 clocks low, keeps scl near 347 kHz
  int hp = 64;

  // both lines released while idle; only this model moves scl
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  task automatic half();
    repeat (hp) @(posedge clock);
  endtask

  // start or repeated start: sda falls while scl is high
  task automatic start();
    sda_rel <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_rel <= 1'b0;
    half();
    scl <= 1'b0;
    half();
  endtask

  // stop: sda rises while scl is high, bus left idle
  task automatic stop();
    sda_rel <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_rel <= 1'b1;
    half();
  endtask

  // one bit; sda sampled early and late in the high phase, x if it moved
  task automatic xfer_bit(input logic b, output logic r);
    logic r1;
    sda_rel <= b;
    half();
    scl <= 1'b1;
    repeat (hp / 4) @(posedge clock);
    r1 = sda_line;
    repeat (hp - hp / 4) @(posedge clock);
    r = sda_line;
    if (r1 !== r) r = 1'bx;
    scl <= 1'b0;
    // hold sda after the fall so no false start or stop is seen
    repeat (hp / 4) @(posedge clock);
  endtask

  task automatic send_byte(input twrs_byte_t v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(v[i], r);
    end
    xfer_bit(1'b1, r);
    ack = ~r;
  endtask

  task automatic recv_byte(input logic more, output twrs_byte_t v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, r);
      v[i] = r;
    end
    xfer_bit(~more, r);
  endtask
endmodule

`default_nettype wire

// [verification/testbench.sv]
/*
  Self-checking bench for the two-wire register slave: bus master model
  on the link, a register file model on the register port.
  Assumes the register file answers a read strobe on the next clock.
*/
`default_nettype none

module testbench
  import twrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock = 1'b0;
  logic link_clk = 1'b0;
  logic resetn = 1'b0;
  logic addr_sel = 1'b0;
  twrs_byte_t reg_rdata = 8'h00;
  logic scl;
  logic sda_rel;
  logic sda_o;
  logic sda_oe;
  logic reg_wr;
  logic reg_rd;
  twrs_byte_t reg_addr;
  twrs_byte_t reg_wdata;
  wire sda_line;
  twrs_byte_t regs [0:255];
  int n_wr = 0;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;

  // open-drain wire with pull-up; the device pulls with its drive value
  assign sda_line = sda_rel & (sda_oe ? sda_o : 1'b1);

  always #10 clock = ~clock;

  // link clock offset so its edges never meet those of clock
  initial begin
    #7;
    forever #15 link_clk = ~link_clk;
  end

  twrs_slave dut_u (
    .clock(clock),
    .resetn(resetn),
    .link_clk(link_clk),
    .scl(scl),
    .sda_i(sda_line),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .addr_sel(addr_sel),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata)
  );

  twrs_master m_u (
    .clock(clock),
    .sda_line(sda_line),
    .scl(scl),
    .sda_rel(sda_rel)
  );

  // register file model; read data is scrambled outside its valid cycle
  always @(posedge clock) begin
    if (reg_wr === 1'b1) begin
      regs[reg_addr] <= reg_wdata;
      n_wr <= n_wr + 1;
    end
    if (reg_rd === 1'b1) reg_rdata <= regs[reg_addr];
    else reg_rdata <= ~reg_rdata;
  end

  // hang guard, well above the roughly 40k cycles the scenarios take
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (n_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // send one byte and judge the ack on the ninth clock
  task automatic tx(input twrs_byte_t v, input logic exp_ack, input string what);
    logic a;
    m_u.send_byte(v, a);
    check(what, {7'h00, exp_ack}, {7'h00, a});
  endtask

  task automatic rx(input logic more, input twrs_byte_t exp, input string what);
    twrs_byte_t v;
    m_u.recv_byte(more, v);
    check(what, exp, v);
  endtask

  task automatic scn_write_burst();
    int n0;
    n0 = n_wr;
    m_u.start();
    tx(8'hc0, 1'b1, "ack_dev_w");
    tx(8'h00, 1'b1, "ack_reg_addr");
    tx(8'h0e, 1'b1, "ack_data0");
    tx(8'hd8, 1'b1, "ack_data1");
    tx(8'he1, 1'b1, "ack_data2");
    m_u.stop();
    check("writes", 8'h03, 8'(n_wr - n0));
    check("reg00", 8'h0e, regs[0]);
    check("reg01", 8'hd8, regs[1]);
    check("reg02", 8'he1, regs[2]);
  endtask

  // read from the top register so the pointer wraps into written ones
  task automatic scn_read_wrap();
    m_u.start();
    tx(8'hc0, 1'b1, "ack_rd_dev_w");
    tx(8'hff, 1'b1, "ack_rd_reg");
    m_u.start();
    tx(8'hc1, 1'b1, "ack_dev_r");
    rx(1'b1, 8'ha5, "rd_ff");
    rx(1'b1, 8'h0e, "rd_00");
    rx(1'b0, 8'hd8, "rd_01");
    m_u.half();
    check("released_after_nack", 8'h00, {7'h00, sda_oe});
    m_u.stop();
    check("idle_release", 8'h00, {7'h00, sda_oe});
  endtask

  // each strap value: own write address acked, the other one ignored
  task automatic scn_strap();
    twrs_byte_t dev;
    int n0;
    for (int s = 0; s < 2; s++) begin
      addr_sel <= s[0];
      repeat (20) @(posedge clock);
      for (int k = 0; k < 2; k++) begin
        dev = (k == 0) ? 8'hc0 : 8'hc2;
        n0 = n_wr;
        m_u.start();
        tx(dev, (k == s), "ack_strap");
        if (k == s) begin
          tx(8'h20, 1'b1, "ack_strap_reg");
          tx(8'h40 + 8'(4 * s + k), 1'b1, "ack_strap_data");
        end
        m_u.stop();
        check("strap_writes", (k == s) ? 8'h01 : 8'h00, 8'(n_wr - n0));
      end
      check("strap_reg", 8'h40 + 8'(5 * s), regs[8'h20]);
    end
    addr_sel <= 1'b0;
    repeat (20) @(posedge clock);
  endtask

  // half a byte cut by stop is dropped; then a slower bus still works
  task automatic scn_partial_slow();
    logic r;
    int n0;
    n0 = n_wr;
    m_u.start();
    tx(8'hc0, 1'b1, "ack_part_dev");
    tx(8'h30, 1'b1, "ack_part_reg");
    for (int i = 0; i < 4; i++) begin
      m_u.xfer_bit(1'b1, r);
    end
    m_u.stop();
    check("partial_writes", 8'h00, 8'(n_wr - n0));
    m_u.hp = 100;
    m_u.start();
    tx(8'hc0, 1'b1, "ack_slow_dev");
    tx(8'h31, 1'b1, "ack_slow_reg");
    tx(8'h99, 1'b1, "ack_slow_data");
    m_u.stop();
    check("slow_reg", 8'h99, regs[8'h31]);
    m_u.hp = 64;
  endtask

  initial begin
    for (int i = 0; i < 256; i++) begin
      regs[i] = 8'(i) ^ 8'h5a;
    end
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    repeat (10) @(posedge clock);
    scn_write_burst();
    scn_read_wrap();
    scn_strap();
    scn_partial_slow();
    end_of_test();
  end
endmodule

`default_nettype wire
